/* sysclk_reference_input_a_pkg.sv */
// Constants shared by the system clock / reference A configuration block.
// Assumes a 100 MHz pclk and an APB register bus with 32-bit data.

// ==========================================================================
// Package
package sysclk_reference_input_a_pkg;

   localparam int PADDR_W = 16;
   localparam int IDX_W = 14;
   localparam int NREG = 11;
   localparam int DIV_W = 20;
   localparam int STAB_W = 20;
   localparam int FREQ_W = 28;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_UPDATE = 14'h000f;
   localparam logic [IDX_W-1:0] IDX_FREQ_B0 = 14'h0202;
   localparam logic [IDX_W-1:0] IDX_FREQ_B1 = 14'h0203;
   localparam logic [IDX_W-1:0] IDX_FREQ_B2 = 14'h0204;
   localparam logic [IDX_W-1:0] IDX_FREQ_B3 = 14'h0205;
   localparam logic [IDX_W-1:0] IDX_STAB_B0 = 14'h0206;
   localparam logic [IDX_W-1:0] IDX_STAB_B1 = 14'h0207;
   localparam logic [IDX_W-1:0] IDX_STAB_B2 = 14'h0208;
   localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0209;
   localparam logic [IDX_W-1:0] IDX_RXTYPE = 14'h0300;
   localparam logic [IDX_W-1:0] IDX_DIV_B0 = 14'h0301;
   localparam logic [IDX_W-1:0] IDX_DIV_B1 = 14'h0302;
   localparam logic [IDX_W-1:0] IDX_DIV_B2 = 14'h0303;

   // Slots of the byte register array
   localparam int R_FREQ0 = 0;
   localparam int R_STAB0 = 4;
   localparam int R_RXTYPE = 7;
   localparam int R_DIV0 = 8;

   localparam logic [NREG-1:0][IDX_W-1:0] REG_IDX = {
      IDX_DIV_B2, IDX_DIV_B1, IDX_DIV_B0, IDX_RXTYPE,
      IDX_STAB_B2, IDX_STAB_B1, IDX_STAB_B0,
      IDX_FREQ_B3, IDX_FREQ_B2, IDX_FREQ_B1, IDX_FREQ_B0};
   localparam logic [NREG-1:0][7:0] REG_RST = {
      8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h32,
      8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [NREG-1:0][7:0] REG_MASK = {
      8'h0f, 8'hff, 8'hff, 8'h03,
      8'h0f, 8'hff, 8'hff,
      8'h0f, 8'hff, 8'hff, 8'hff};

   localparam logic [7:0] UPDATE_GO = 8'h01;

   // Status register bits
   localparam int ST_STABLE = 0;
   localparam int ST_LOCKED = 1;
   localparam int ST_COUNTING = 2;
   localparam int ST_HALTED = 3;

   // Receiver types
   localparam logic [1:0] RX_CMOS = 2'h0;
   localparam logic [1:0] RX_ACDIFF = 2'h1;
   localparam logic [1:0] RX_LVDS = 2'h2;
   localparam logic [1:0] RX_UNUSED = 2'h3;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_TIME_NS = 1_000_000;
   localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {tm_halted, tm_counting, tm_stable} timer_e;

endpackage : sysclk_reference_input_a_pkg

/* reference_input_a_predivider.sv */
// Integer predivider for the received reference A signal.
// Assumes clk_in is already sampled on pclk and far slower than pclk/2.

`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Predivider
module reference_input_a_predivider #(
   parameter int DIV_W = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_in,
   input wire logic [DIV_W-1:0] div_m1,
   output logic div_pulse
);

   if (DIV_W < 1 || DIV_W > 32) begin : g_chk
      $error("reference_input_a_predivider: DIV_W out of range");
   end

   logic in_prev_q;
   logic [DIV_W-1:0] cnt_q;
   logic pulse_q;
   wire rise = clk_in & ~in_prev_q;
   // A shrinking divisor must not leave the count stranded above it
   wire wrap = cnt_q >= div_m1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_prev_q <= 1'b0;
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         in_prev_q <= clk_in;
         pulse_q <= rise & wrap;
         if (rise) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
         end
      end
   end

   assign div_pulse = pulse_q;

   // ======================================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   div_pulse_a: assert property (rise && wrap |=> div_pulse)
      else $error("predivider missed its output pulse");
   div_quiet_a: assert property (!(rise && wrap) |=> !div_pulse)
      else $error("predivider pulsed without a terminal edge");
   div_one_a: assert property (
      div_m1 == '0 && rise |=> div_pulse && cnt_q == '0)
      else $error("divide by one did not pass every edge");

endmodule : reference_input_a_predivider

`default_nettype wire

/* sysclk_reference_input_a_config.sv */
// System clock stability timer, reference frequency store and reference A
// receiver / predivider configuration, reached over APB.
// Assumes pll_locked and reference_input_a pins are synchronous to pclk.
//
// Our own choice: the APB slave port.

`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Top
module sysclk_reference_input_a_config #(
   parameter int MS_CYCLES = sysclk_reference_input_a_pkg::MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sysclk_reference_input_a_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pll_locked,
   input wire logic reference_input_a_p,
   input wire logic reference_input_a_n,
   output logic sysclk_stable,
   output logic [sysclk_reference_input_a_pkg::FREQ_W-1:0] sysclk_ref_freq_hz,
   output logic [sysclk_reference_input_a_pkg::STAB_W-1:0] stability_ms,
   output logic [1:0] reference_input_a_rx_type,
   output logic [sysclk_reference_input_a_pkg::DIV_W-1:0] reference_input_a_div_m1,
   output logic reference_input_a_rx,
   output logic reference_input_a_div_pulse
);

   localparam int MSW = $clog2(MS_CYCLES);
   localparam int NREG = sysclk_reference_input_a_pkg::NREG;
   localparam int IDX_W = sysclk_reference_input_a_pkg::IDX_W;
   localparam int STAB_W = sysclk_reference_input_a_pkg::STAB_W;

   // Ticks need three cycles between them for the spacing check to hold
   if (MS_CYCLES < 3) begin : g_chk_ms
      $error("sysclk_reference_input_a_config: MS_CYCLES must be at least 3");
   end

   // ======================================================================
   // Address decode
   function automatic logic in_range(input logic [IDX_W-1:0] idx,
                                     input logic [IDX_W-1:0] lo,
                                     input logic [IDX_W-1:0] hi);
      in_range = (idx >= lo) && (idx <= hi);
   endfunction : in_range

   wire [IDX_W-1:0] idx = paddr[sysclk_reference_input_a_pkg::PADDR_W-1:2];
   wire aligned = paddr[1:0] == 2'h0;
   wire hit_freq_stab = in_range(idx, sysclk_reference_input_a_pkg::IDX_FREQ_B0,
                                 sysclk_reference_input_a_pkg::IDX_STAB_B2);
   wire hit_reference_input_a = in_range(idx, sysclk_reference_input_a_pkg::IDX_RXTYPE,
                            sysclk_reference_input_a_pkg::IDX_DIV_B2);
   wire hit_stab = in_range(idx, sysclk_reference_input_a_pkg::IDX_STAB_B0,
                            sysclk_reference_input_a_pkg::IDX_STAB_B2);
   wire hit_status = idx == sysclk_reference_input_a_pkg::IDX_STATUS;
   wire hit_update = idx == sysclk_reference_input_a_pkg::IDX_UPDATE;
   wire mapped = aligned &
                 (hit_freq_stab | hit_reference_input_a | hit_status | hit_update);
   wire access = psel & penable;
   wire wr_en = access & pwrite & mapped & pstrb[0];
   wire setup_rd = psel & ~penable & ~pwrite;
   wire stab_wr = wr_en & hit_stab;
   wire upd_go = wr_en & hit_update &
                 (pwdata[7:0] == sysclk_reference_input_a_pkg::UPDATE_GO);

   // Zero wait states: every transfer completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ======================================================================
   // Byte registers
   logic [7:0] reg_q [NREG];

   for (genvar g = 0; g < NREG; g++) begin : g_reg
      wire hit = wr_en && aligned && idx == sysclk_reference_input_a_pkg::REG_IDX[g];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            reg_q[g] <= sysclk_reference_input_a_pkg::REG_RST[g];
         end else if (hit) begin
            // Reserved bits are masked away at the write
            reg_q[g] <= pwdata[7:0] & sysclk_reference_input_a_pkg::REG_MASK[g];
         end
      end
   end

   assign sysclk_ref_freq_hz = {
      reg_q[sysclk_reference_input_a_pkg::R_FREQ0+3][3:0],
      reg_q[sysclk_reference_input_a_pkg::R_FREQ0+2],
      reg_q[sysclk_reference_input_a_pkg::R_FREQ0+1],
      reg_q[sysclk_reference_input_a_pkg::R_FREQ0]};
   assign stability_ms = {
      reg_q[sysclk_reference_input_a_pkg::R_STAB0+2][3:0],
      reg_q[sysclk_reference_input_a_pkg::R_STAB0+1],
      reg_q[sysclk_reference_input_a_pkg::R_STAB0]};
   assign reference_input_a_rx_type = reg_q[sysclk_reference_input_a_pkg::R_RXTYPE][1:0];
   assign reference_input_a_div_m1 = {
      reg_q[sysclk_reference_input_a_pkg::R_DIV0+2][3:0],
      reg_q[sysclk_reference_input_a_pkg::R_DIV0+1],
      reg_q[sysclk_reference_input_a_pkg::R_DIV0]};

   // ======================================================================
   // Stability timer
   sysclk_reference_input_a_pkg::timer_e state_q;
   sysclk_reference_input_a_pkg::timer_e state_d;
   logic [STAB_W-1:0] cnt_q;
   logic [STAB_W-1:0] cnt_d;
   logic [MSW-1:0] ms_q;

   wire counting = state_q == sysclk_reference_input_a_pkg::tm_counting;
   wire ms_tick = counting & pll_locked &
                  (ms_q == MSW'(MS_CYCLES - 1));
   wire reached = cnt_q >= stability_ms;

   // The millisecond divider only runs while a count is in progress, so
   // every restart begins on a whole-millisecond boundary
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_q <= '0;
      end else if (!counting || !pll_locked || ms_tick) begin
         ms_q <= '0;
      end else begin
         ms_q <= ms_q + 1'b1;
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         sysclk_reference_input_a_pkg::tm_halted: begin
            if (upd_go) begin
               state_d = sysclk_reference_input_a_pkg::tm_counting;
               cnt_d = '0;
            end
         end
         sysclk_reference_input_a_pkg::tm_counting: begin
            if (stab_wr) begin
               state_d = sysclk_reference_input_a_pkg::tm_halted;
               cnt_d = '0;
            end else if (!pll_locked) begin
               cnt_d = '0;
            end else if (reached) begin
               state_d = sysclk_reference_input_a_pkg::tm_stable;
            end else if (ms_tick) begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         sysclk_reference_input_a_pkg::tm_stable: begin
            if (stab_wr) begin
               state_d = sysclk_reference_input_a_pkg::tm_halted;
               cnt_d = '0;
            end else if (!pll_locked) begin
               state_d = sysclk_reference_input_a_pkg::tm_counting;
               cnt_d = '0;
            end
         end
         default: begin
            state_d = sysclk_reference_input_a_pkg::tm_halted;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= sysclk_reference_input_a_pkg::tm_counting;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   assign sysclk_stable = state_q == sysclk_reference_input_a_pkg::tm_stable;

   // ======================================================================
   // Read path
   logic [7:0] rd_byte;
   logic [31:0] prdata_q;
   wire [7:0] status = {4'h0,
                        state_q == sysclk_reference_input_a_pkg::tm_halted,
                        counting, pll_locked, sysclk_stable};

   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (idx == sysclk_reference_input_a_pkg::REG_IDX[i]) begin
            rd_byte = reg_q[i];
         end
      end
      if (hit_status) begin
         rd_byte = status;
      end
      if (!aligned) begin
         rd_byte = 8'h00;
      end
   end

   // Read data is caught in the setup cycle and held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   assign prdata = prdata_q;

   // ======================================================================
   // Reference A receiver
   logic rx_q;
   wire rx_d = (reference_input_a_rx_type == sysclk_reference_input_a_pkg::RX_CMOS) ?
               reference_input_a_p :
               (reference_input_a_rx_type == sysclk_reference_input_a_pkg::RX_UNUSED) ?
               1'b0 : (reference_input_a_p & ~reference_input_a_n);

   // Differential types resolve the pair as a comparator would; the
   // unused code parks the receiver low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q <= 1'b0;
      end else begin
         rx_q <= rx_d;
      end
   end

   assign reference_input_a_rx = rx_q;

   reference_input_a_predivider #(
      .DIV_W(sysclk_reference_input_a_pkg::DIV_W)
   ) u_prediv (
      .pclk(pclk),
      .presetn(presetn),
      .clk_in(rx_q),
      .div_m1(reference_input_a_div_m1),
      .div_pulse(reference_input_a_div_pulse)
   );

   // ======================================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence stab_write_s;
      stab_wr;
   endsequence

   sequence restart_s;
      state_q == sysclk_reference_input_a_pkg::tm_halted && upd_go;
   endsequence

   sequence halted_idle_s;
      state_q == sysclk_reference_input_a_pkg::tm_halted && !upd_go;
   endsequence

   lock_loss_drop_a: assert property (
      !pll_locked |=> !sysclk_stable)
      else $error("stable held without lock");
   stable_reach_a: assert property (
      $rose(sysclk_stable) |-> $past(cnt_q) >= $past(stability_ms))
      else $error("stable declared before the period elapsed");
   write_clears_a: assert property (
      stab_write_s |=> !sysclk_stable && cnt_q == '0 &&
                       state_q == sysclk_reference_input_a_pkg::tm_halted)
      else $error("stability write did not reset the count");
   halt_holds_a: assert property (halted_idle_s |=>
      state_q == sysclk_reference_input_a_pkg::tm_halted && cnt_q == '0)
      else $error("timer left halt without update");
   update_restart_a: assert property (restart_s |=>
      counting && cnt_q == '0)
      else $error("update did not restart the count");
   tick_period_a: assert property (
      ms_tick |=> !ms_tick [*2])
      else $error("millisecond ticks too close");
   freq_top_a: assert property (
      wr_en && idx == sysclk_reference_input_a_pkg::IDX_FREQ_B3 |=>
      sysclk_ref_freq_hz[27:24] == $past(pwdata[3:0]))
      else $error("frequency top nibble not stored");
   unused_low_a: assert property (
      reference_input_a_rx_type == sysclk_reference_input_a_pkg::RX_UNUSED |=> !reference_input_a_rx)
      else $error("unused receiver type drove the input");
   cmos_true_a: assert property (
      reference_input_a_rx_type == sysclk_reference_input_a_pkg::RX_CMOS |=> reference_input_a_rx == $past(reference_input_a_p))
      else $error("CMOS mode did not follow the true pin");
   rsvd_zero_a: assert property (
      access && !pwrite |-> prdata[31:8] == 24'h00_0000 &&
      (!(idx == sysclk_reference_input_a_pkg::IDX_STAB_B2) || prdata[7:4] == 4'h0))
      else $error("reserved read bits not zero");

   // Bits that a read may show at an index; every other bit reads zero
   function automatic logic [7:0] rd_mask(input logic [IDX_W-1:0] i);
      rd_mask = 8'h00;
      for (int r = 0; r < NREG; r++) begin
         if (i == sysclk_reference_input_a_pkg::REG_IDX[r]) begin
            rd_mask = sysclk_reference_input_a_pkg::REG_MASK[r];
         end
      end
      if (i == sysclk_reference_input_a_pkg::IDX_STATUS) begin
         rd_mask = 8'((1 << (sysclk_reference_input_a_pkg::ST_HALTED + 1)) - 1);
      end
   endfunction : rd_mask

   sequence lock_lost_s;
      counting && !pll_locked && !stab_wr;
   endsequence

   sequence refused_write_s;
      access && pwrite && !wr_en;
   endsequence

   rd_mask_a: assert property (
      access && !pwrite |-> (prdata[7:0] & ~rd_mask(idx)) == 8'h00)
      else $error("read showed a reserved bit");
   refused_keep_a: assert property (refused_write_s |=>
      $stable(sysclk_ref_freq_hz) && $stable(stability_ms) &&
      $stable(reference_input_a_rx_type) && $stable(reference_input_a_div_m1))
      else $error("refused write changed a register");
   lock_hold_a: assert property (lock_lost_s |=>
      counting && cnt_q == '0 && !sysclk_stable)
      else $error("count survived a loss of lock");
   diff_pair_a: assert property (
      reference_input_a_rx_type == sysclk_reference_input_a_pkg::RX_ACDIFF ||
      reference_input_a_rx_type == sysclk_reference_input_a_pkg::RX_LVDS |=>
      reference_input_a_rx == $past(reference_input_a_p && !reference_input_a_n))
      else $error("differential receiver did not resolve the pair");
   update_idle_a: assert property (
      upd_go && sysclk_stable && pll_locked |=> sysclk_stable)
      else $error("update strobe disturbed a stable clock");

endmodule : sysclk_reference_input_a_config

`default_nettype wire

/* tb_sysclk_reference_input_a_config.sv */
// Self-checking bench for the system clock / reference A config block.
// Assumes the block answers on APB with pready and uses MS_CYCLES of 10.

`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench
module tb_sysclk_reference_input_a_config;
   localparam int MS = 10;
   logic pclk, presetn, psel, penable, pwrite, pll_locked, reference_input_a_p, reference_input_a_n;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic pready, pslverr, sysclk_stable, reference_input_a_rx, reference_input_a_div_pulse, er;
   logic ok, exp_bit;
   logic [27:0] freq;
   logic [19:0] stab, div;
   logic [1:0] rxt;
   logic [7:0] pat, msk;
   int fails, samples_checked, pulses, n;

   sysclk_reference_input_a_config #(.MS_CYCLES(MS)) sysclk_reference_input_a_config_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pll_locked(pll_locked), .reference_input_a_p(reference_input_a_p), .reference_input_a_n(reference_input_a_n),
      .sysclk_stable(sysclk_stable), .sysclk_ref_freq_hz(freq),
      .stability_ms(stab), .reference_input_a_rx_type(rxt), .reference_input_a_div_m1(div),
      .reference_input_a_rx(reference_input_a_rx), .reference_input_a_div_pulse(reference_input_a_div_pulse));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (reference_input_a_div_pulse === 1'b1) pulses++;
   end

   // ========================================================================
   // Tasks
   task automatic stop_test;
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [13:0] idx,
         input logic [7:0] d, input logic [3:0] s);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge pclk);
      end
      if (pready !== 1'b1) begin
         fails++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One spare edge lets the stored byte reach the outputs before a check
   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 4'hf);
      @(posedge pclk);
   endtask : wr

   task automatic wait_stable(input int lim);
      n = 0;
      while (sysclk_stable !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_stable

   task automatic edges(input int cnt);
      repeat (cnt) begin
         reference_input_a_p <= 1'b1;
         repeat (2) @(posedge pclk);
         reference_input_a_p <= 1'b0;
         repeat (2) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask : edges

   // ========================================================================
   // Watchdog: whole run is about a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      stop_test();
   end

   // ========================================================================
   // Tests
   initial begin
      {presetn, psel, penable, pwrite, reference_input_a_p, reference_input_a_n} = 6'h00;
      {paddr, pwdata, pstrb} = 52'h0;
      pll_locked = 1'b1;
      fails = 0;
      samples_checked = 0;
      pulses = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Default period of 50 ms with lock held from reset
      wait_stable(600);
      ok = n >= 50*MS && n <= 50*MS+4;
      chk("default_stable_delay", 1, ok);
      apb(1'b0, sysclk_reference_input_a_pkg::IDX_STATUS, 8'h00, 4'hf);
      chk("status_stable", 32'h03, rd);
      chk("mapped_err", 0, er);
      pll_locked <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("stable_after_unlock", 0, sysclk_stable);
      pll_locked <= 1'b1;
      // Reset values, then a pattern with every reserved bit set except bit 2 of the receiver type
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, sysclk_reference_input_a_pkg::REG_IDX[i], 8'h00, 4'hf);
         chk("reset_value", (i == 4) ? 32'h32 : 32'h0, rd);
      end
      for (int i = 0; i < 11; i++) begin
         pat = 8'hf1 + 8'(i);
         msk = (i == 7) ? 8'h03 : 8'hff;
         if (i == 3 || i == 6 || i == 10) begin
            msk = 8'h0f;
         end
         wr(sysclk_reference_input_a_pkg::REG_IDX[i], pat);
         apb(1'b0, sysclk_reference_input_a_pkg::REG_IDX[i], 8'h00, 4'hf);
         chk("masked_readback", {24'h0, pat & msk}, rd);
      end
      chk("ref_freq", 32'h4f3f2f1, freq);
      chk("stab_period", 32'h7f6f5, stab);
      chk("rx_type", 0, rxt);
      chk("div_m1", 32'hbfaf9, div);
      apb(1'b1, sysclk_reference_input_a_pkg::IDX_FREQ_B0, 8'h00, 4'h0);
      apb(1'b0, sysclk_reference_input_a_pkg::IDX_FREQ_B0, 8'h00, 4'hf);
      chk("no_strobe_write", 32'hf1, rd);
      // Status is read only; the period writes above left the timer halted
      wr(sysclk_reference_input_a_pkg::IDX_STATUS, 8'hff);
      apb(1'b0, sysclk_reference_input_a_pkg::IDX_STATUS, 8'h00, 4'hf);
      chk("status_halted", 32'h0a, rd);
      apb(1'b0, sysclk_reference_input_a_pkg::IDX_UPDATE, 8'h00, 4'hf);
      chk("update_reads_zero", 0, rd);
      apb(1'b0, 14'h0100, 8'h00, 4'hf);
      chk("unmapped_err", 1, er);
      chk("unmapped_data", 0, rd);
      // Period of 3 ms, held until a real update strobe
      wr(sysclk_reference_input_a_pkg::IDX_STAB_B0, 8'h03);
      wr(sysclk_reference_input_a_pkg::IDX_STAB_B1, 8'h00);
      wr(sysclk_reference_input_a_pkg::IDX_STAB_B2, 8'h00);
      chk("stab_period_3", 3, stab);
      repeat (50) @(posedge pclk);
      chk("halted_no_count", 0, sysclk_stable);
      wr(sysclk_reference_input_a_pkg::IDX_UPDATE, 8'h02);
      repeat (50) @(posedge pclk);
      chk("bad_update_ignored", 0, sysclk_stable);
      wr(sysclk_reference_input_a_pkg::IDX_UPDATE, 8'h01);
      wait_stable(60);
      ok = n >= 3*MS && n <= 3*MS+4;
      chk("stable_delay", 1, ok);
      wr(sysclk_reference_input_a_pkg::IDX_UPDATE, 8'h01);
      chk("update_while_stable", 1, sysclk_stable);
      wr(sysclk_reference_input_a_pkg::IDX_STAB_B1, 8'h00);
      repeat (2) @(posedge pclk);
      chk("write_withdraws", 0, sysclk_stable);
      wr(sysclk_reference_input_a_pkg::IDX_UPDATE, 8'h01);
      repeat (15) @(posedge pclk);
      wr(sysclk_reference_input_a_pkg::IDX_STAB_B0, 8'h03);
      wr(sysclk_reference_input_a_pkg::IDX_UPDATE, 8'h01);
      wait_stable(60);
      ok = n >= 3*MS && n <= 3*MS+4;
      chk("count_restarted", 1, ok);
      // Receiver type against every pin combination
      for (int t = 0; t < 4; t++) begin
         wr(sysclk_reference_input_a_pkg::IDX_RXTYPE, 8'(t));
         chk("rx_type_out", t, rxt);
         for (int pn = 0; pn < 4; pn++) begin
            reference_input_a_p <= pn[1];
            reference_input_a_n <= pn[0];
            repeat (3) @(posedge pclk);
            exp_bit = (t == 0) ? pn[1] : (pn[1] & ~pn[0]);
            if (t == 3) begin
               exp_bit = 1'b0;
            end
            chk("reference_input_a_rx", exp_bit, reference_input_a_rx);
         end
      end
      // Predivider: divide by field plus one
      reference_input_a_p <= 1'b0;
      reference_input_a_n <= 1'b1;
      wr(sysclk_reference_input_a_pkg::IDX_RXTYPE, 8'h00);
      wr(sysclk_reference_input_a_pkg::IDX_DIV_B1, 8'h00);
      wr(sysclk_reference_input_a_pkg::IDX_DIV_B2, 8'h00);
      wr(sysclk_reference_input_a_pkg::IDX_DIV_B0, 8'h00);
      pulses = 0;
      edges(5);
      chk("div_by_one", 5, pulses);
      wr(sysclk_reference_input_a_pkg::IDX_DIV_B0, 8'h02);
      pulses = 0;
      edges(12);
      chk("div_by_three", 4, pulses);
      stop_test();
   end
endmodule : tb_sysclk_reference_input_a_config

`default_nettype wire
